// *** src/rtd_regs.sv ***
// Control register bank with power-up defaults and factory trim loading
`timescale 1ns/1ps
// What this block does
// - First power-up clears stop, century, test, signs, trims, enables; sets pin level, square wave.
// - First power-up clears repeats, timer, rates, lock, alarm-2; sets halt, fail, sources, rate0.
// - Backup power-up clears test, watchdog, timer run; sets halt; others keep value.
// - Unlisted control bits clear at first power-up, one legal choice where they are otherwise undefined.
// - Lock set copies factory trim into calibration register 12h, read-only.
// - Lock clear makes calibration register plain read/write storage.
// - Factory trim value is fixed at manufacture and never user writable.
// - Pin level is bit 7, frequency test bit 6 of register 08h.
module rtd_regs #(
   parameter int LOAD_CYCLES = rtd_pkg::OTP_LOAD_CYCLES,
   parameter logic [7:0] TRIM_VALUE = rtd_pkg::OTP_TRIM_DEFAULT
) (
   // Clock and first power application
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Power events
   input wire logic i_backup_pwr_up,
   input wire logic i_osc_fail_evt,
   // Register port
   input wire logic i_reg_wr,
   input wire logic [4:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // Control outputs
   output logic o_freq_test_en,
   output logic o_out_level,
   output logic o_halt_update,
   output logic o_timer_run,
   output logic o_trim_lock,
   output logic o_trim_loading,
   output logic [7:0] o_analog_trim
);

   typedef struct packed {
      rtd_pkg::rtd_ctl_t ctl;
      logic start;
      logic loading;
      logic [7:0] rdata;
   } rtd_st_t;

   rtd_st_t st_reg;
   rtd_st_t st_next;

   rtd_otp_if otp_bus ();

   rtd_otp #(
      .LOAD_CYCLES(LOAD_CYCLES),
      .TRIM_VALUE(TRIM_VALUE)
   ) u_otp (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .otp(otp_bus.rom)
   );

   assign otp_bus.start = st_reg.start;

   // Read mux; unlisted bits read zero
   function automatic logic [7:0] reg_read(input rtd_pkg::rtd_ctl_t c, input logic [4:0] addr);
      logic [7:0] d;
      d = rtd_pkg::RD_UNMAPPED;
      case (addr)
         rtd_pkg::ADDR_SECONDS: begin
            d[rtd_pkg::BIT_OSC_STOP] = c.osc_stop_bit;
         end
         rtd_pkg::ADDR_CENTURY: begin
            d[rtd_pkg::BIT_CENT_HIGH] = c.century_bit_high;
            d[rtd_pkg::BIT_CENT_LOW] = c.century_bit_low;
         end
         rtd_pkg::ADDR_DIG_CAL: begin
            d[rtd_pkg::BIT_OUT_LEVEL] = c.out_level;
            d[rtd_pkg::BIT_FREQ_TEST] = c.freq_test_enable;
            d[rtd_pkg::BIT_DIG_SIGN] = c.digital_trim_sign;
            d[4:0] = c.digital_trim;
         end
         rtd_pkg::ADDR_WATCHDOG: begin
            d[rtd_pkg::BIT_OSC_FAIL_IE] = c.osc_fail_irq_en;
            d[6:2] = c.watchdog_multiplier;
            d[rtd_pkg::BIT_WD_RES_HIGH] = c.watchdog_resolution_high;
            d[rtd_pkg::BIT_WD_RES_LOW] = c.watchdog_resolution_low;
         end
         rtd_pkg::ADDR_ALM1_MON: begin
            d[rtd_pkg::BIT_ALM1_IE] = c.alarm1_irq_en;
            d[rtd_pkg::BIT_SQW_EN] = c.square_wave_en;
            d[rtd_pkg::BIT_ALM_BACKUP] = c.alarm_backup_en;
         end
         rtd_pkg::ADDR_ALM1_RPT: begin
            d[4:0] = c.alarm1_repeat_bits;
         end
         rtd_pkg::ADDR_HALT: begin
            d[rtd_pkg::BIT_HALT] = c.halt_update_flag;
         end
         rtd_pkg::ADDR_FLAGS: begin
            d[rtd_pkg::BIT_OSC_FAIL] = c.osc_fail_flag;
         end
         rtd_pkg::ADDR_TMR_CTL: begin
            d[rtd_pkg::BIT_TMR_RUN] = c.timer_run;
            d[rtd_pkg::BIT_TMR_IRQ_PULSE] = c.timer_irq_pulse_sel;
            d[rtd_pkg::BIT_TMR_IRQ_EN] = c.timer_irq_en;
            d[rtd_pkg::BIT_TMR_SRC_HIGH] = c.timer_source_sel_high;
            d[rtd_pkg::BIT_TMR_SRC_LOW] = c.timer_source_sel_low;
         end
         rtd_pkg::ADDR_ANA_CAL: begin
            d[rtd_pkg::BIT_ANA_SIGN] = c.analog_trim_sign;
            d[6:0] = c.analog_trim;
         end
         rtd_pkg::ADDR_SQW: begin
            d[7:5] = c.rate_select_upper;
            d[rtd_pkg::BIT_RATE_LOW] = c.rate_select_low;
            d[rtd_pkg::BIT_TRIM_LOCK] = c.trim_lock;
         end
         rtd_pkg::ADDR_ALM2: begin
            d[rtd_pkg::BIT_ALM2_IE] = c.alarm2_irq_en;
            d[rtd_pkg::BIT_ALM2_EN] = c.alarm2_enable;
            d[4:0] = c.alarm2_repeat_bits;
         end
         default: begin
            d = rtd_pkg::RD_UNMAPPED;
         end
      endcase
      return d;
   endfunction

   always_comb begin
      st_next = st_reg;
      st_next.start = 1'b0;
      if (i_reg_wr) begin
         case (i_reg_addr)
            rtd_pkg::ADDR_SECONDS: begin
               st_next.ctl.osc_stop_bit = i_reg_wdata[rtd_pkg::BIT_OSC_STOP];
            end
            rtd_pkg::ADDR_CENTURY: begin
               st_next.ctl.century_bit_high = i_reg_wdata[rtd_pkg::BIT_CENT_HIGH];
               st_next.ctl.century_bit_low = i_reg_wdata[rtd_pkg::BIT_CENT_LOW];
            end
            rtd_pkg::ADDR_DIG_CAL: begin
               st_next.ctl.out_level = i_reg_wdata[rtd_pkg::BIT_OUT_LEVEL];
               st_next.ctl.freq_test_enable = i_reg_wdata[rtd_pkg::BIT_FREQ_TEST];
               st_next.ctl.digital_trim_sign = i_reg_wdata[rtd_pkg::BIT_DIG_SIGN];
               st_next.ctl.digital_trim = i_reg_wdata[4:0];
            end
            rtd_pkg::ADDR_WATCHDOG: begin
               st_next.ctl.osc_fail_irq_en = i_reg_wdata[rtd_pkg::BIT_OSC_FAIL_IE];
               st_next.ctl.watchdog_multiplier = i_reg_wdata[6:2];
               st_next.ctl.watchdog_resolution_high = i_reg_wdata[rtd_pkg::BIT_WD_RES_HIGH];
               st_next.ctl.watchdog_resolution_low = i_reg_wdata[rtd_pkg::BIT_WD_RES_LOW];
            end
            rtd_pkg::ADDR_ALM1_MON: begin
               st_next.ctl.alarm1_irq_en = i_reg_wdata[rtd_pkg::BIT_ALM1_IE];
               st_next.ctl.square_wave_en = i_reg_wdata[rtd_pkg::BIT_SQW_EN];
               st_next.ctl.alarm_backup_en = i_reg_wdata[rtd_pkg::BIT_ALM_BACKUP];
            end
            rtd_pkg::ADDR_ALM1_RPT: begin
               st_next.ctl.alarm1_repeat_bits = i_reg_wdata[4:0];
            end
            rtd_pkg::ADDR_HALT: begin
               st_next.ctl.halt_update_flag = i_reg_wdata[rtd_pkg::BIT_HALT];
            end
            rtd_pkg::ADDR_FLAGS: begin
               st_next.ctl.osc_fail_flag = i_reg_wdata[rtd_pkg::BIT_OSC_FAIL];
            end
            rtd_pkg::ADDR_TMR_CTL: begin
               st_next.ctl.timer_run = i_reg_wdata[rtd_pkg::BIT_TMR_RUN];
               st_next.ctl.timer_irq_pulse_sel = i_reg_wdata[rtd_pkg::BIT_TMR_IRQ_PULSE];
               st_next.ctl.timer_irq_en = i_reg_wdata[rtd_pkg::BIT_TMR_IRQ_EN];
               st_next.ctl.timer_source_sel_high = i_reg_wdata[rtd_pkg::BIT_TMR_SRC_HIGH];
               st_next.ctl.timer_source_sel_low = i_reg_wdata[rtd_pkg::BIT_TMR_SRC_LOW];
            end
            rtd_pkg::ADDR_ANA_CAL: begin
               if (!st_reg.ctl.trim_lock) begin
                  st_next.ctl.analog_trim_sign = i_reg_wdata[rtd_pkg::BIT_ANA_SIGN];
                  st_next.ctl.analog_trim = i_reg_wdata[6:0];
               end
            end
            rtd_pkg::ADDR_SQW: begin
               st_next.ctl.rate_select_upper = i_reg_wdata[7:5];
               st_next.ctl.rate_select_low = i_reg_wdata[rtd_pkg::BIT_RATE_LOW];
               st_next.ctl.trim_lock = i_reg_wdata[rtd_pkg::BIT_TRIM_LOCK];
               // Only the rising edge of lock starts a slow read
               if (i_reg_wdata[rtd_pkg::BIT_TRIM_LOCK] && !st_reg.ctl.trim_lock) begin
                  st_next.start = 1'b1;
                  st_next.loading = 1'b1;
               end
            end
            rtd_pkg::ADDR_ALM2: begin
               st_next.ctl.alarm2_irq_en = i_reg_wdata[rtd_pkg::BIT_ALM2_IE];
               st_next.ctl.alarm2_enable = i_reg_wdata[rtd_pkg::BIT_ALM2_EN];
               st_next.ctl.alarm2_repeat_bits = i_reg_wdata[4:0];
            end
            default: begin
            end
         endcase
      end
      // Oscillator event wins over a software clear in the same cycle
      if (i_osc_fail_evt) begin
         st_next.ctl.osc_fail_flag = 1'b1;
      end
      // Unlocking mid-read drops the pending copy
      if (!st_next.ctl.trim_lock) begin
         st_next.loading = 1'b0;
      end
      if (otp_bus.done && st_reg.loading && st_next.ctl.trim_lock) begin
         st_next.ctl.analog_trim_sign = otp_bus.trim[rtd_pkg::BIT_ANA_SIGN];
         st_next.ctl.analog_trim = otp_bus.trim[6:0];
         st_next.loading = 1'b0;
      end
      // Backup power-up overrides software in the same cycle
      if (i_backup_pwr_up) begin
         st_next.ctl.freq_test_enable = 1'b0;
         st_next.ctl.watchdog_multiplier = '0;
         st_next.ctl.watchdog_resolution_high = 1'b0;
         st_next.ctl.watchdog_resolution_low = 1'b0;
         st_next.ctl.timer_run = 1'b0;
         st_next.ctl.halt_update_flag = 1'b1;
      end
      st_next.rdata = reg_read(st_next.ctl, i_reg_addr);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // Unlisted bits also clear here, which is one legal choice
         st_reg.ctl <= rtd_pkg::CTL_INIT;
         st_reg.start <= 1'b0;
         st_reg.loading <= 1'b0;
         st_reg.rdata <= rtd_pkg::RD_UNMAPPED;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_reg_rdata = st_reg.rdata;
   assign o_freq_test_en = st_reg.ctl.freq_test_enable;
   assign o_out_level = st_reg.ctl.out_level;
   assign o_halt_update = st_reg.ctl.halt_update_flag;
   assign o_timer_run = st_reg.ctl.timer_run;
   assign o_trim_lock = st_reg.ctl.trim_lock;
   assign o_trim_loading = st_reg.loading;
   assign o_analog_trim = {st_reg.ctl.analog_trim_sign, st_reg.ctl.analog_trim};

endmodule

// *** inc/rtd_pkg.sv ***
// Shared constants, register map and control-bit layout for the RTC defaults block
package rtd_pkg;

   // Register offsets
   localparam logic [4:0] ADDR_SECONDS = 5'h01;
   localparam logic [4:0] ADDR_CENTURY = 5'h03;
   localparam logic [4:0] ADDR_DIG_CAL = 5'h08;
   localparam logic [4:0] ADDR_WATCHDOG = 5'h09;
   localparam logic [4:0] ADDR_ALM1_MON = 5'h0A;
   localparam logic [4:0] ADDR_ALM1_RPT = 5'h0B;
   localparam logic [4:0] ADDR_HALT = 5'h0C;
   localparam logic [4:0] ADDR_FLAGS = 5'h0F;
   localparam logic [4:0] ADDR_TMR_CTL = 5'h11;
   localparam logic [4:0] ADDR_ANA_CAL = 5'h12;
   localparam logic [4:0] ADDR_SQW = 5'h13;
   localparam logic [4:0] ADDR_ALM2 = 5'h14;

   // Bit positions
   localparam int BIT_OSC_STOP = 7;
   localparam int BIT_CENT_HIGH = 7;
   localparam int BIT_CENT_LOW = 6;
   localparam int BIT_OUT_LEVEL = 7;
   localparam int BIT_FREQ_TEST = 6;
   localparam int BIT_DIG_SIGN = 5;
   localparam int BIT_OSC_FAIL_IE = 7;
   localparam int BIT_WD_RES_HIGH = 1;
   localparam int BIT_WD_RES_LOW = 0;
   localparam int BIT_ALM1_IE = 7;
   localparam int BIT_SQW_EN = 6;
   localparam int BIT_ALM_BACKUP = 5;
   localparam int BIT_HALT = 6;
   localparam int BIT_OSC_FAIL = 2;
   localparam int BIT_TMR_RUN = 7;
   localparam int BIT_TMR_IRQ_PULSE = 6;
   localparam int BIT_TMR_IRQ_EN = 5;
   localparam int BIT_TMR_SRC_HIGH = 1;
   localparam int BIT_TMR_SRC_LOW = 0;
   localparam int BIT_ANA_SIGN = 7;
   localparam int BIT_RATE_LOW = 4;
   localparam int BIT_TRIM_LOCK = 3;
   localparam int BIT_ALM2_IE = 7;
   localparam int BIT_ALM2_EN = 6;

   // Timing of the nonvolatile trim read
   localparam int CLK_HZ = 50_000_000;
   localparam int OTP_LOAD_MS = 8;
   localparam int OTP_LOAD_CYCLES = OTP_LOAD_MS * (CLK_HZ / 1000);
   localparam int OTP_CNT_W = 20;

   // Factory trim contents; value is arbitrary
   localparam logic [7:0] OTP_TRIM_DEFAULT = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   typedef struct packed {
      logic osc_stop_bit;
      logic century_bit_high;
      logic century_bit_low;
      logic out_level;
      logic freq_test_enable;
      logic digital_trim_sign;
      logic [4:0] digital_trim;
      logic analog_trim_sign;
      logic [6:0] analog_trim;
      logic osc_fail_irq_en;
      logic [4:0] watchdog_multiplier;
      logic watchdog_resolution_high;
      logic watchdog_resolution_low;
      logic alarm1_irq_en;
      logic square_wave_en;
      logic alarm_backup_en;
      logic [4:0] alarm1_repeat_bits;
      logic halt_update_flag;
      logic osc_fail_flag;
      logic timer_run;
      logic timer_irq_pulse_sel;
      logic timer_irq_en;
      logic timer_source_sel_high;
      logic timer_source_sel_low;
      logic rate_select_low;
      logic [2:0] rate_select_upper;
      logic trim_lock;
      logic alarm2_irq_en;
      logic [4:0] alarm2_repeat_bits;
      logic alarm2_enable;
   } rtd_ctl_t;

   // Initial power-up defaults
   localparam rtd_ctl_t CTL_INIT = '{
      out_level: 1'b1,
      square_wave_en: 1'b1,
      halt_update_flag: 1'b1,
      osc_fail_flag: 1'b1,
      timer_source_sel_high: 1'b1,
      timer_source_sel_low: 1'b1,
      rate_select_low: 1'b1,
      default: '0
   };

endpackage

// *** inc/rtd_otp_if.sv ***
// Handshake between the register bank and the factory trim store
`timescale 1ns/1ps
interface rtd_otp_if;
   logic start;
   logic done;
   logic [7:0] trim;

   modport ctl (output start, input done, input trim);
   modport rom (input start, output done, output trim);
endinterface

// *** src/rtd_otp.sv ***
// Factory trim store with its slow read sequence
`timescale 1ns/1ps
module rtd_otp #(
   parameter int LOAD_CYCLES = rtd_pkg::OTP_LOAD_CYCLES,
   parameter logic [7:0] TRIM_VALUE = rtd_pkg::OTP_TRIM_DEFAULT
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Trim handshake
   rtd_otp_if.rom otp
);

   typedef struct packed {
      logic busy;
      logic [rtd_pkg::OTP_CNT_W-1:0] cnt;
      logic done;
      logic [7:0] trim;
   } rtd_otp_st_t;

   rtd_otp_st_t st_reg;
   rtd_otp_st_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (otp.start) begin
         st_next.busy = 1'b1;
         st_next.cnt = '0;
      end else if (st_reg.busy) begin
         if (st_reg.cnt == rtd_pkg::OTP_CNT_W'(LOAD_CYCLES - 1)) begin
            // Content is fixed; no write path exists
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
            st_next.trim = TRIM_VALUE;
         end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign otp.done = st_reg.done;
   assign otp.trim = st_reg.trim;

endmodule

// *** dv/rtd_regs_checker.sv ***
// Assertion checker for the RTC control defaults and trim loader
`timescale 1ns/1ps
module rtd_regs_checker #(
   parameter int LOAD_CYCLES = 10,
   parameter logic [7:0] TRIM_VALUE = 8'h00
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Inputs
   input wire logic i_backup_pwr_up,
   input wire logic i_osc_fail_evt,
   input wire logic i_reg_wr,
   input wire logic [4:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   // Outputs
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_freq_test_en,
   input wire logic o_out_level,
   input wire logic o_halt_update,
   input wire logic o_timer_run,
   input wire logic o_trim_lock,
   input wire logic o_trim_loading,
   input wire logic [7:0] o_analog_trim
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   // Length of the running trim load, bounds the slow copy
   logic [19:0] load_len_reg;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         load_len_reg <= '0;
      end else if (o_trim_loading) begin
         load_len_reg <= load_len_reg + 20'h00001;
      end else begin
         load_len_reg <= '0;
      end
   end
   sequence s_lock_req;
      i_reg_wr && i_reg_addr == rtd_pkg::ADDR_SQW && i_reg_wdata[rtd_pkg::BIT_TRIM_LOCK] && !o_trim_lock
         && !i_backup_pwr_up;
   endsequence
   sequence s_load_end;
      o_trim_loading ##1 (!o_trim_loading && o_trim_lock);
   endsequence
   sequence s_cal_wr;
      i_reg_wr && i_reg_addr == rtd_pkg::ADDR_ANA_CAL && !o_trim_loading;
   endsequence
   AST_RST_DEFAULT: assert property ($rose(i_rst_n) |-> o_out_level && o_halt_update
      && !o_freq_test_en && !o_timer_run && !o_trim_lock && o_analog_trim == 8'h00)
      else $error("reset defaults wrong");
   AST_BKUP_CLR: assert property (i_backup_pwr_up |=> !o_freq_test_en && o_halt_update && !o_timer_run)
      else $error("backup power-up did not force bits");
   AST_BKUP_KEEP: assert property (i_backup_pwr_up && !i_reg_wr && !o_trim_loading |=>
      $stable(o_out_level) && $stable(o_trim_lock) && $stable(o_analog_trim))
      else $error("backup power-up changed kept bits");
   AST_LOAD_START: assert property (s_lock_req |=> o_trim_lock && o_trim_loading)
      else $error("trim load did not start");
   AST_LOAD_DONE: assert property (s_load_end |-> o_analog_trim == TRIM_VALUE)
      else $error("factory trim not copied");
   AST_LOAD_LEN: assert property (o_trim_loading |-> load_len_reg <= LOAD_CYCLES + 2)
      else $error("trim load too long");
   AST_LOCK_RO: assert property (s_cal_wr and o_trim_lock |=> $stable(o_analog_trim))
      else $error("locked calibration written");
   AST_RW_PLAIN: assert property (s_cal_wr and !o_trim_lock |=> o_analog_trim == $past(i_reg_wdata))
      else $error("calibration write lost");
   // Flag event seen through the read port, since the flag has no pin
   AST_OSC_SET: assert property (i_osc_fail_evt && i_reg_addr == rtd_pkg::ADDR_FLAGS |=>
      o_reg_rdata[rtd_pkg::BIT_OSC_FAIL])
      else $error("oscillator fail flag not set");
   AST_OUT_BITS: assert property (i_reg_wr && i_reg_addr == rtd_pkg::ADDR_DIG_CAL && !i_backup_pwr_up |=>
      {o_out_level, o_freq_test_en} == $past(i_reg_wdata[7:6]))
      else $error("pin level or test bit misplaced");
endmodule
bind rtd_regs rtd_regs_checker #(.LOAD_CYCLES(LOAD_CYCLES), .TRIM_VALUE(TRIM_VALUE)) u_chk (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_backup_pwr_up(i_backup_pwr_up), .i_osc_fail_evt(i_osc_fail_evt),
   .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
   .o_freq_test_en(o_freq_test_en), .o_out_level(o_out_level), .o_halt_update(o_halt_update),
   .o_timer_run(o_timer_run), .o_trim_lock(o_trim_lock), .o_trim_loading(o_trim_loading),
   .o_analog_trim(o_analog_trim));

// *** dv/tb.sv ***
// Self-checking bench for the RTC control defaults and trim loader
`timescale 1ns/1ps
module tb;
   localparam int LC = 10;
   localparam logic [7:0] TRIM = 8'hA5;
   logic i_sys_clk, i_rst_n, i_backup_pwr_up, i_osc_fail_evt, i_reg_wr, rd_req, rd_now;
   logic [4:0] i_reg_addr;
   logic [7:0] i_reg_wdata, o_reg_rdata, o_analog_trim;
   logic o_freq_test_en, o_out_level, o_halt_update, o_timer_run, o_trim_lock, o_trim_loading;
   logic [7:0] exp_q[$];
   logic [7:0] shadow [12];
   logic [4:0] addrs [12] = '{5'h01, 5'h03, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0F, 5'h11, 5'h12, 5'h13, 5'h14};
   logic [7:0] dflt [12] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h40, 8'h00, 8'h40, 8'h04, 8'h03, 8'h00, 8'h10, 8'h00};
   // Lock bit left out of the mask so random fill never starts a load
   logic [7:0] wmask [12] = '{8'h80, 8'hC0, 8'hFF, 8'hFF, 8'hE0, 8'h1F, 8'h40, 8'h04, 8'hE3, 8'hFF, 8'hF0, 8'hDF};
   int n_mismatch = 0;
   int samples_checked = 0;
   int seed = 32'h7D62;
   int cnt;
   rtd_regs #(.LOAD_CYCLES(LC), .TRIM_VALUE(TRIM)) uut (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_backup_pwr_up(i_backup_pwr_up), .i_osc_fail_evt(i_osc_fail_evt),
      .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .o_freq_test_en(o_freq_test_en), .o_out_level(o_out_level), .o_halt_update(o_halt_update),
      .o_timer_run(o_timer_run), .o_trim_lock(o_trim_lock), .o_trim_loading(o_trim_loading),
      .o_analog_trim(o_analog_trim));
   initial begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end
   task automatic summarize;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp(input string name, input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, e, s);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge i_sys_clk);
      i_reg_wr = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      rd_req = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      @(negedge i_sys_clk);
      i_reg_wr = 1'b0;
      i_reg_addr = a;
      rd_req = 1'b1;
      exp_q.push_back(e);
   endtask
   task automatic idle(input int n);
      @(negedge i_sys_clk);
      i_reg_wr = 1'b0;
      rd_req = 1'b0;
      repeat (n) @(negedge i_sys_clk);
   endtask
   task automatic pulse(input logic bk, input logic of);
      idle(0);
      i_backup_pwr_up = bk;
      i_osc_fail_evt = of;
      @(negedge i_sys_clk);
      i_backup_pwr_up = 1'b0;
      i_osc_fail_evt = 1'b0;
   endtask
   task automatic do_reset;
      idle(0);
      i_rst_n = 1'b0;
      repeat (12) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
   endtask
   task automatic chk_dflt;
      for (int i = 0; i < 12; i++) begin
         rd(addrs[i], dflt[i]);
      end
      rd(5'h1F, 8'h00);
      idle(0);
      cmp("halt_update", 8'h01, 8'(o_halt_update));
   endtask
   // Read data is registered: compare one clock after the address
   always @(posedge i_sys_clk) rd_now <= rd_req;
   always @(negedge i_sys_clk) begin
      if (rd_now === 1'b1) begin
         cmp("reg_rdata", exp_q.pop_front(), o_reg_rdata);
      end
   end
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      n_mismatch++;
      summarize;
   end
   initial begin
      i_backup_pwr_up = 1'b0;
      i_osc_fail_evt = 1'b0;
      i_reg_wr = 1'b0;
      i_reg_addr = 5'h00;
      i_reg_wdata = 8'h00;
      rd_req = 1'b0;
      i_rst_n = 1'b0;
      do_reset;
      chk_dflt;
      for (int i = 0; i < 12; i++) begin
         shadow[i] = 8'($random(seed)) & wmask[i];
         wr(addrs[i], shadow[i]);
      end
      wr(5'h1F, 8'hFF);
      pulse(1'b1, 1'b0);
      cmp("timer_run", 8'h00, 8'(o_timer_run));
      shadow[2] &= 8'hBF;
      shadow[3] &= 8'h80;
      shadow[6] |= 8'h40;
      shadow[8] &= 8'h7F;
      for (int i = 0; i < 12; i++) begin
         rd(addrs[i], shadow[i]);
      end
      rd(5'h1F, 8'h00);
      wr(5'h0F, 8'h00);
      pulse(1'b0, 1'b1);
      rd(5'h0F, 8'h04);
      // Clear and event in one cycle: the event must win
      wr(5'h0F, 8'h00);
      i_osc_fail_evt = 1'b1;
      rd(5'h0F, 8'h04);
      i_osc_fail_evt = 1'b0;
      for (int v = 0; v < 2; v++) begin
         wr(5'h08, v ? 8'h40 : 8'h80);
         idle(0);
         cmp("out_level", v ? 8'h00 : 8'h01, 8'(o_out_level));
         cmp("freq_test", v ? 8'h01 : 8'h00, 8'(o_freq_test_en));
      end
      // Lock, with a write racing the slow copy
      wr(5'h13, 8'h08);
      wr(5'h12, 8'h5A);
      idle(0);
      cmp("trim_loading", 8'h01, 8'(o_trim_loading));
      cmp("trim_lock", 8'h01, 8'(o_trim_lock));
      cnt = 0;
      while (o_trim_loading === 1'b1 && cnt < 100) begin
         @(negedge i_sys_clk);
         cnt++;
      end
      cmp("load_len_ok", 8'h01, 8'(cnt >= LC - 1 && cnt <= LC + 1));
      rd(5'h12, TRIM);
      wr(5'h12, 8'($random(seed)));
      rd(5'h12, TRIM);
      idle(0);
      cmp("analog_trim", TRIM, o_analog_trim);
      wr(5'h13, 8'h00);
      wr(5'h12, 8'h3C);
      rd(5'h12, 8'h3C);
      // Abort a load, then reset in mid-load
      wr(5'h13, 8'h08);
      wr(5'h13, 8'h00);
      idle(LC + 5);
      rd(5'h12, 8'h3C);
      wr(5'h13, 8'h08);
      idle(2);
      do_reset;
      chk_dflt;
      // Let the last queued read be compared before the verdict
      idle(1);
      summarize;
   end
endmodule
